// file: bench/pmsr_regs_test.sv
/*
  Self-checking bench for the power mode, identity and status registers.
  Assumes the register port answers one cycle after each request and drives all pins itself.
*/
module pmsr_regs_test import pmsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] TB_IDENT = 32'h0000_3c71;  // Arbitrary value.

  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          clk_en = 1'b1;
  pmsr_bus_req_t bus_req = '0;
  logic          test_acc = 1'b0;
  logic          test_keep = 1'b0;
  logic    [2:0] locks = 3'h0;
  logic    [2:0] ev = 3'h0;
  logic          adapt = 1'b1;
  logic          batt = 1'b1;
  logic          irq = 1'b0;
  logic          dma = 1'b0;
  logic          grant = 1'b0;
  logic          bus_ready;
  logic   [31:0] bus_rdata;
  logic          bus_master;
  logic    [2:0] mode_code;
  logic          rst_n;
  logic   [31:0] exp_q[$];
  logic   [31:0] exp_v;
  logic   [31:0] rnd;
  logic    [2:0] mask;
  int            seed = 18803;
  int            errors = 0;
  int            n_checks = 0;
  int            n_low;

  always #20 ref_clk = ~ref_clk;

  pmsr_regs #(.REV_IDENT(TB_IDENT)) i_dut (
    .ref_clk_in            (ref_clk),
    .sys_rst_in            (sys_rst),
    .clk_en_in             (clk_en),
    .bus_req_in            (bus_req),
    .bus_ready_out         (bus_ready),
    .bus_rdata_out         (bus_rdata),
    .test_access_in        (test_acc),
    .test_clk_keep_in      (test_keep),
    .pll_lock_in           (locks),
    .wake_key_n_in         (~ev[0]),
    .ring_event_in         (ev[1]),
    .rtc_event_in          (ev[2]),
    .adaptor_good_input_in (adapt),
    .battery_good_input_in (batt),
    .cpu_irq_in            (irq),
    .dma_req_in            (dma),
    .bus_grant_in          (grant),
    .bus_master_req_out    (bus_master),
    .mode_code_out         (mode_code),
    .system_reset_n_out    (rst_n)
  );

  //////////////////////////////////////////////////////////////////////////////

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Every request notes its expected read word; writes answer with zero.
  task automatic bus_op(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] e);
    @(negedge ref_clk);
    bus_req = '{sel: 1'b1, write: w, addr: a, wdata: d};
    exp_q.push_back(e);
    @(negedge ref_clk);
    bus_req.sel = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus_op(1'b0, a, 32'h0, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus_op(1'b1, a, d, 32'h0);
  endtask

  task automatic wait_code(input logic [2:0] code, input int lim);
    int n;
    n = 0;
    while (mode_code !== code && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check("mode_code", {29'h0, mode_code}, {29'h0, code});
    if (mode_code !== code) give_verdict();
  endtask

  task automatic pulse_ev(input logic [2:0] m);
    ev = m;
    cyc(4);
    ev = 3'h0;
    cyc(4);
  endtask

  // Sleep is reached only through idle with the bus granted; waking obeys the permission bit.
  task automatic sleep_pass(input logic perm);
    wr(PMSR_OFS_MODE, {28'h0, perm, PMSR_CODE_SLEEP});
    cyc(6);
    wait_code(PMSR_CODE_IDLE, 1);
    grant = 1'b1;
    wait_code(PMSR_CODE_SLEEP, 20);
    grant = 1'b0;
    wr(PMSR_OFS_MODE, 32'h1);
    cyc(2);
    wait_code(PMSR_CODE_SLEEP, 1);
    adapt = 1'b0;
    batt = 1'b0;
    cyc(4);
    pulse_ev(3'b001);
    wait_code(perm ? PMSR_CODE_IDLE : PMSR_CODE_SLEEP, 1);
    if (!perm) begin
      batt = 1'b1;
      cyc(4);
      pulse_ev(3'b001);
      wait_code(PMSR_CODE_IDLE, 20);
    end
    adapt = 1'b1;
    batt = 1'b1;
    if (perm) irq = 1'b1;
    else dma = 1'b1;
    cyc(2);
    irq = 1'b0;
    dma = 1'b0;
    wait_code(PMSR_CODE_SLOW, 20);
  endtask

  //////////////////////////////////////////////////////////////////////////////

  always @(negedge ref_clk) begin
    if (bus_ready === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
      check("bus_rdata", bus_rdata, exp_v);
    end
  end

  initial begin
    cyc(20);
    sys_rst = 1'b0;
    check("reset_mode", {29'h0, mode_code}, {29'h0, PMSR_CODE_INIT});
    check("reset_out", {31'h0, rst_n}, 32'h1);
    rd(PMSR_OFS_STAT, 32'h001);
    rd(PMSR_OFS_MODE, 32'h0);
    rd(PMSR_OFS_IDENT, TB_IDENT);
    rd(12'h030, 32'h0);
    $display("test reset done");

    locks = 3'h7;
    wait_code(PMSR_CODE_SLOW, 20);
    rd(PMSR_OFS_STAT, 32'h00f);
    wr(PMSR_OFS_STAT, 32'h001);
    rd(PMSR_OFS_STAT, 32'h00e);
    $display("test lock done");

    wr(PMSR_OFS_MODE, 32'hffff_fff9);
    rd(PMSR_OFS_MODE, 32'h9);
    wait_code(PMSR_CODE_RUN, 1);
    wr(PMSR_OFS_MODE, 32'h0);
    rd(PMSR_OFS_MODE, 32'h0);
    wr(PMSR_OFS_MODE, {29'h0, PMSR_CODE_INIT});
    wait_code(PMSR_CODE_INIT, 1);
    wait_code(PMSR_CODE_SLOW, 5);
    rnd = $random(seed);
    wr(PMSR_OFS_IDENT, rnd);
    rd(PMSR_OFS_IDENT, TB_IDENT);
    $display("test mode codes done");

    wr(PMSR_OFS_MODE, {29'h0, PMSR_CODE_IDLE});
    wait_code(PMSR_CODE_IDLE, 5);
    check("master_idle", {31'h0, bus_master}, 32'h1);
    rd(PMSR_OFS_MODE, 32'h0);
    test_acc = 1'b1;
    rd(PMSR_OFS_MODE, 32'h0);
    test_keep = 1'b1;
    rd(PMSR_OFS_MODE, {29'h0, PMSR_CODE_IDLE});
    test_acc = 1'b0;
    test_keep = 1'b0;
    irq = 1'b1;
    cyc(2);
    irq = 1'b0;
    wait_code(PMSR_CODE_SLOW, 20);
    check("master_slow", {31'h0, bus_master}, 32'h0);
    $display("test idle done");

    sleep_pass(1'b0);
    sleep_pass(1'b1);
    $display("test sleep done");

    wr(PMSR_OFS_STAT, 32'h1f0);
    rd(PMSR_OFS_STAT, 32'h00e);
    rnd = $random(seed);
    mask = rnd[2:0] | 3'b010;
    pulse_ev(mask);
    rd(PMSR_OFS_STAT, {23'h0, 1'b0, 1'b0, mask, 4'he});
    wr(PMSR_OFS_STAT, 32'h0);
    check("no_warm", {31'h0, rst_n}, 32'h1);
    rd(PMSR_OFS_STAT, {23'h0, 1'b0, 1'b0, mask, 4'he});
    wr(PMSR_OFS_STAT, {25'h0, mask, 4'h0});
    rd(PMSR_OFS_STAT, 32'h00e);
    $display("test events done");

    // Events while the clock enable is low must leave every bit as it was.
    cyc(1);
    clk_en = 1'b0;
    pulse_ev(3'b110);
    clk_en = 1'b1;
    cyc(4);
    rd(PMSR_OFS_STAT, 32'h00e);
    check("frozen_mode", {29'h0, mode_code}, {29'h0, PMSR_CODE_SLOW});
    $display("test freeze done");

    wr(PMSR_OFS_STAT, 32'h0001_0000);
    n_low = 0;
    while (rst_n === 1'b0 && n_low < 100) begin
      n_low++;
      @(negedge ref_clk);
    end
    check("warm_len", n_low, PMSR_WARM_RST_CYC);
    wait_code(PMSR_CODE_SLOW, 20);
    rd(PMSR_OFS_STAT, 32'h10e);
    cyc(3);
    check("queue_left", exp_q.size(), 32'h0);
    $display("test warm reset done");
    give_verdict();
  end

endmodule // pmsr_regs_test

// file: rtl/pmsr_pkg.sv
/*
  Constants, types and helpers shared by the power mode and status register block.
  Assumes one 25 MHz clock and a 12-bit byte offset inside the power unit's window.
*/
package pmsr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets within the power unit window.
  localparam logic [11:0] PMSR_OFS_MODE  = 12'h000;
  localparam logic [11:0] PMSR_OFS_IDENT = 12'h010;
  localparam logic [11:0] PMSR_OFS_STAT  = 12'h020;

  //////////////////////////////////////////////////////////////////////////////
  // Mode select field and its codes.
  localparam int          PMSR_MODE_SEL_LSB = 0;
  localparam int          PMSR_MODE_WAKE_BIT = 3;
  localparam logic [2:0]  PMSR_CODE_INIT  = 3'h4;
  localparam logic [2:0]  PMSR_CODE_RUN   = 3'h1;
  localparam logic [2:0]  PMSR_CODE_SLOW  = 3'h0;
  localparam logic [2:0]  PMSR_CODE_IDLE  = 3'h2;
  localparam logic [2:0]  PMSR_CODE_SLEEP = 3'h3;
  localparam logic        PMSR_WAKE_PERM_RST = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Status register layout.
  localparam int          PMSR_STAT_POR       = 0;
  localparam int          PMSR_STAT_PLL1      = 1;
  localparam int          PMSR_STAT_WAKE      = 4;
  localparam int          PMSR_STAT_RING      = 5;
  localparam int          PMSR_STAT_RTC       = 6;
  localparam int          PMSR_STAT_ADAPT     = 7;
  localparam int          PMSR_STAT_WARM      = 8;
  localparam int          PMSR_STAT_WARM_TRIG = 16;
  localparam int          PMSR_STICKY_W       = 9;
  localparam logic [8:0]  PMSR_STICKY_RST     = 9'h001;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int          PMSR_CLK_PERIOD_NS = 40;
  localparam int          PMSR_WARM_RST_NS   = 1000;
  localparam int          PMSR_WARM_RST_CYC  =
    (PMSR_WARM_RST_NS + PMSR_CLK_PERIOD_NS - 1) / PMSR_CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    PMSR_ST_INIT,
    PMSR_ST_RUN,
    PMSR_ST_SLOW,
    PMSR_ST_IDLE,
    PMSR_ST_SLEEP
  } pmsr_state_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pmsr_bus_req_t;

  function automatic logic [2:0] pmsr_state_code(input pmsr_state_t st);
    logic [2:0] code;
    code = PMSR_CODE_INIT;
    unique case (st)
      PMSR_ST_INIT:  code = PMSR_CODE_INIT;
      PMSR_ST_RUN:   code = PMSR_CODE_RUN;
      PMSR_ST_SLOW:  code = PMSR_CODE_SLOW;
      PMSR_ST_IDLE:  code = PMSR_CODE_IDLE;
      PMSR_ST_SLEEP: code = PMSR_CODE_SLEEP;
      default:       code = PMSR_CODE_INIT;
    endcase
    return code;
  endfunction

endpackage

// file: rtl/pmsr_regs.sv
/*
  Power mode select, revision identity and reset/lock/event status registers,
  with the mode state machine they command and the warm reset generator.
  Assumes a single-cycle register port on the same clock and asynchronous pins
  for lock, wake key, ring, real-time clock, adaptor-good and battery-good.
*/
// Function
// (R1) Mode register accessible only in run or slow
// (R2) Processor mode reads show only run or slow
// (R3) Test controller reads other codes with clocks kept
// (R4) Mode codes: init 4, run 1, slow 0, idle 2, sleep 3
// (R5) Bit 3 permits wake with adaptor, battery low
// (R6) Identity register is read-only fixed revision code
// (R7) Status: POR, three locks, wake, ring, RTC, adaptor
// (R8) Event bits stay set after source goes away
// (R9) Writing one to status bit 16 pulses reset
// (R10) Software reads status after each reset exit
// (R11) Sticky bits set by event, cleared by processor
// (R12) Software clears sticky bit by writing one
// (R13) Sleep entered only from idle with bus granted
// (R14) Reserved bits read zero, writes ignored
module pmsr_regs
  import pmsr_pkg::*;
#(
  parameter logic [31:0] REV_IDENT = 32'h0000_0a5c  // Arbitrary value.
) (
  input  wire logic          ref_clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          clk_en_in,
  input  wire pmsr_bus_req_t bus_req_in,
  output logic               bus_ready_out,
  output logic        [31:0] bus_rdata_out,
  input  wire logic          test_access_in,
  input  wire logic          test_clk_keep_in,
  input  wire logic    [2:0] pll_lock_in,
  input  wire logic          wake_key_n_in,
  input  wire logic          ring_event_in,
  input  wire logic          rtc_event_in,
  input  wire logic          adaptor_good_input_in,
  input  wire logic          battery_good_input_in,
  input  wire logic          cpu_irq_in,
  input  wire logic          dma_req_in,
  input  wire logic          bus_grant_in,
  output logic               bus_master_req_out,
  output logic         [2:0] mode_code_out,
  output logic               system_reset_n_out
);

  localparam int          PIN_W   = 8;
  // Synchronisers come up showing quiet events and good supplies, so no false event follows reset.
  localparam logic [PIN_W-1:0] PIN_IDLE = 8'hc0;
  localparam logic [7:0]  RST_CYC = 8'(PMSR_WARM_RST_CYC);

  initial begin
    if (PMSR_WARM_RST_CYC < 1 || PMSR_WARM_RST_CYC > 255)
      $error("pmsr_regs: warm reset length does not fit its counter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Only the second stage is read.
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {battery_good_input_in, adaptor_good_input_in, rtc_event_in,
                    ring_event_in, ~wake_key_n_in, pll_lock_in};

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_meta_q <= PIN_IDLE;
      pin_sync_q <= PIN_IDLE;
    end else if (clk_en_in) begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire [2:0] pll_lock_s = pin_sync_q[2:0];
  wire       wake_key_s = pin_sync_q[3];
  wire       ring_s     = pin_sync_q[4];
  wire       rtc_s      = pin_sync_q[5];
  wire       adaptor_s  = pin_sync_q[6];
  wire       battery_s  = pin_sync_q[7];

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  pmsr_state_t state_q;
  pmsr_state_t state_d;
  logic        wake_perm_q;
  logic        sleep_pend_q;
  logic        sleep_pend_d;
  logic  [7:0] rst_cnt_q;
  logic [31:0] rdata_q;
  logic        ready_q;

  wire        hit_mode   = bus_req_in.sel && bus_req_in.addr == PMSR_OFS_MODE;
  wire        hit_ident  = bus_req_in.sel && bus_req_in.addr == PMSR_OFS_IDENT;
  wire        hit_stat   = bus_req_in.sel && bus_req_in.addr == PMSR_OFS_STAT;
  wire        cpu_active = state_q == PMSR_ST_RUN || state_q == PMSR_ST_SLOW;
  wire        test_view  = test_access_in && test_clk_keep_in;
  wire        mode_wr    = hit_mode && bus_req_in.write && cpu_active; // R1
  wire        stat_wr    = hit_stat && bus_req_in.write;
  wire  [2:0] cmd_code   = bus_req_in.wdata[PMSR_MODE_SEL_LSB +: 3];
  wire        warm_trig  = stat_wr && bus_req_in.wdata[PMSR_STAT_WARM_TRIG]; // R9
  wire  [2:0] cur_code   = pmsr_state_code(state_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status bits. Bit 0 comes up set to flag the power-on reset.
  logic [PMSR_STICKY_W-1:0] sticky;
  logic [PMSR_STICKY_W-1:0] sticky_set;
  logic [PMSR_STICKY_W-1:0] sticky_clr;

  // Adaptor status records the adaptor-good line dropping out.
  assign sticky_set = {warm_trig, ~adaptor_s, rtc_s, ring_s, wake_key_s,
                       pll_lock_s, 1'b0}; // R7
  assign sticky_clr = stat_wr ? bus_req_in.wdata[PMSR_STICKY_W-1:0]
                              : '0; // R12

  pmsr_sticky #(
    .WIDTH   (PMSR_STICKY_W),
    .RST_VAL (PMSR_STICKY_RST)
  ) u_sticky (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .set_in     (sticky_set),
    .clr_in     (sticky_clr),
    .bits_out   (sticky)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode state machine.
  wire wake_evt = wake_key_s || ring_s || rtc_s;
  // With both supplies reported bad, waking needs explicit permission.
  wire wake_ok  = wake_evt && (wake_perm_q || adaptor_s || battery_s); // R5

  always_comb begin
    state_d      = state_q;
    sleep_pend_d = sleep_pend_q;
    unique case (state_q)
      PMSR_ST_INIT: begin
        if (&pll_lock_s) state_d = PMSR_ST_SLOW;
      end
      PMSR_ST_RUN, PMSR_ST_SLOW: begin
        if (mode_wr) begin
          unique case (cmd_code) // R4
            PMSR_CODE_RUN:  state_d = PMSR_ST_RUN;
            PMSR_CODE_SLOW: state_d = PMSR_ST_SLOW;
            PMSR_CODE_IDLE: state_d = PMSR_ST_IDLE;
            PMSR_CODE_INIT: state_d = PMSR_ST_INIT;
            PMSR_CODE_SLEEP: begin
              // Sleep is reached by way of idle so the bus is ours first.
              state_d      = PMSR_ST_IDLE; // R13
              sleep_pend_d = 1'b1;
            end
            default: state_d = state_q;
          endcase
        end
      end
      PMSR_ST_IDLE: begin
        if (sleep_pend_q && bus_grant_in) begin
          state_d      = PMSR_ST_SLEEP; // R13
          sleep_pend_d = 1'b0;
        end else if (!sleep_pend_q && (cpu_irq_in || dma_req_in)) begin
          state_d = PMSR_ST_SLOW;
        end
      end
      PMSR_ST_SLEEP: begin
        if (wake_ok) state_d = PMSR_ST_IDLE;
      end
      default: state_d = PMSR_ST_INIT;
    endcase
    if (warm_trig) begin
      state_d      = PMSR_ST_INIT;
      sleep_pend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q      <= PMSR_ST_INIT;
      sleep_pend_q <= 1'b0;
    end else if (clk_en_in) begin
      state_q      <= state_d;
      sleep_pend_q <= sleep_pend_d;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_perm_q <= PMSR_WAKE_PERM_RST;
    end else if (clk_en_in && mode_wr) begin
      wake_perm_q <= bus_req_in.wdata[PMSR_MODE_WAKE_BIT]; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Warm reset: a fixed-length low pulse on the system reset output.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_cnt_q <= 8'h00;
    end else if (clk_en_in) begin
      if (warm_trig) rst_cnt_q <= RST_CYC; // R9
      else if (rst_cnt_q != 8'h00) rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. Outside run and slow a processor read of the mode register sees
  // zero; only the test view exposes the other codes.
  wire        mode_rd_ok = cpu_active || test_view; // R1 R3
  wire  [2:0] mode_view  = (cpu_active || test_view) ? cur_code : PMSR_CODE_SLOW; // R2
  wire [31:0] mode_word  = mode_rd_ok ? {28'h0, wake_perm_q, mode_view} : 32'h0; // R14
  wire [31:0] stat_word  = {23'h0, sticky}; // R7 R14
  wire [31:0] rdata_d    = hit_mode  ? mode_word :
                           hit_ident ? REV_IDENT : // R6
                           hit_stat  ? stat_word : 32'h0;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0;
      ready_q <= 1'b0;
    end else if (clk_en_in) begin
      rdata_q <= (bus_req_in.sel && !bus_req_in.write) ? rdata_d : 32'h0;
      ready_q <= bus_req_in.sel;
    end
  end

  assign bus_ready_out      = ready_q;
  assign bus_rdata_out      = rdata_q;
  assign bus_master_req_out = state_q == PMSR_ST_IDLE || state_q == PMSR_ST_SLEEP;
  assign mode_code_out      = cur_code;
  assign system_reset_n_out = rst_cnt_q == 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_MODE_LOCKED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R1
    clk_en_in && hit_mode && bus_req_in.write && !cpu_active && !warm_trig
    |=> $stable(wake_perm_q))
    else $error("mode register changed outside run or slow");

  AST_MODE_READ_CODE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R2
    clk_en_in && hit_mode && !bus_req_in.write && !test_view
    |=> bus_rdata_out[2:1] == 2'b00)
    else $error("processor read showed a code other than run or slow");

  AST_TEST_VIEW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R3
    clk_en_in && hit_mode && !bus_req_in.write && test_view
    |=> bus_rdata_out[2:0] == $past(cur_code))
    else $error("test read did not show the current mode code");

  AST_RUN_CMD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R4
    clk_en_in && mode_wr && cmd_code == PMSR_CODE_RUN && !warm_trig
    |=> mode_code_out == PMSR_CODE_RUN)
    else $error("run command not obeyed");

  AST_WAKE_BLOCKED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R5
    clk_en_in && state_q == PMSR_ST_SLEEP && !wake_perm_q && !adaptor_s && !battery_s
    && !warm_trig |=> state_q == PMSR_ST_SLEEP)
    else $error("woke without permission while supplies were bad");

  AST_IDENT_READ: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R6
    clk_en_in && hit_ident && !bus_req_in.write |=> bus_rdata_out == REV_IDENT)
    else $error("identity read returned a wrong value");

  AST_STICKY_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R8
    clk_en_in |=> (sticky & $past(sticky & ~sticky_clr)) == $past(sticky & ~sticky_clr))
    else $error("sticky bit dropped without a clear");

  AST_STICKY_SET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R11
    clk_en_in |=> (sticky & $past(sticky_set)) == $past(sticky_set))
    else $error("event did not set its sticky bit");

  AST_WARM_PULSE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R9
    clk_en_in && warm_trig |=> !system_reset_n_out && rst_cnt_q == RST_CYC)
    else $error("warm reset not asserted");

  AST_SLEEP_FROM_IDLE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R13
    $rose(state_q == PMSR_ST_SLEEP) |-> $past(state_q == PMSR_ST_IDLE && bus_grant_in))
    else $error("sleep entered without idle and bus grant");

  AST_RESERVED_ZERO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // R14
    bus_ready_out |-> bus_rdata_out[31:17] == 15'h0 || $past(hit_ident))
    else $error("reserved bits read non-zero");

  COV_SLEEP: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    state_q == PMSR_ST_IDLE ##1 state_q == PMSR_ST_SLEEP);
  COV_WAKE: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    state_q == PMSR_ST_SLEEP ##1 state_q == PMSR_ST_IDLE);
  COV_WARM: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $fell(system_reset_n_out));

endmodule // pmsr_regs

// file: rtl/pmsr_sticky.sv
/*
  Bank of sticky status bits: set by an event, cleared only by a write of one.
  Assumes set and clear arrive synchronous to the clock.
*/
module pmsr_sticky #(
  parameter int               WIDTH   = 9,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] bits_out
);

  initial begin
    if (WIDTH < 1) $error("pmsr_sticky: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] bits_q;
  logic [WIDTH-1:0] bits_d;

  // A set in the same cycle as its clear wins, so no event is lost.
  assign bits_d   = (bits_q & ~clr_in) | set_in; // R8 R11

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bits_q <= RST_VAL;
    end else if (clk_en_in) begin
      bits_q <= bits_d;
    end
  end

  assign bits_out = bits_q;

endmodule // pmsr_sticky
